// file: bench/phase_zone_sequencer_tb.sv
// Self-checking bench for the phase zone sequencer.
// Assumes the package timing: 150000-cycle init, 1000 cycles per code.
`timescale 1ns/1ps
module phase_zone_sequencer_tb;
  import pzs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, enable = 1'b0, nominal = 1'b0;
  logic sense = 1'b0, cfg_write = 1'b0, flt = 1'b0;
  pzs_fault_s fault = '0;
  pzs_cfg_s strap = {3'h4, 3'h3, 32'hffffffff};  // Strapped thresholds off
  pzs_cfg_s cfg = {3'h4, 3'h3, 32'hff604020};
  pzs_sel_e want_sel = PZS_SEL_LOW, sel;
  logic [7:0] cur = 8'h10;
  logic vdi, vdf, pg, ramp, dbo, dboe, uvlo;
  logic [3:0] pwm, pst;
  logic [2:0] zone;
  int bad_count = 0, samples_checked = 0, i, na, nb;
  always #5 clk = ~clk;
  pzs_host host (.clk(clk), .want_sel(want_sel), .float_req(flt),
    .power_saving_select(sel), .voltage_duty_input(vdi),
    .duty_input_float(vdf));
  pzs_sequencer dut (.clk(clk), .rst(rst), .enable(enable), .fault(fault),
    .output_nominal(nominal), .ramp_supply_sense(sense),
    .ss_resistor_code(8'h01), .phase_sense_positive(4'h8),
    .power_saving_select(sel), .fixed_zone_strap(strap),
    .cfg_write(cfg_write), .cfg_data(cfg), .shed_delay_steps(8'h03),
    .hysteresis(8'h10), .total_current_monitor(cur),
    .voltage_duty_input(vdi), .duty_input_float(vdf),
    .power_good_out(pg), .ramp_active(ramp), .pwm_enable(pwm),
    .phase_status(pst), .power_zone(zone), .duty_buffer_out(dbo),
    .duty_buffer_oe(dboe), .ramp_uvlo(uvlo));
  // Compare one value and report a mismatch at once
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Disabled, lockout input low: no lockout reported
  task t_idle;
    chk(pg, 0);
    chk(uvlo, 0);
  endtask : t_idle
  // Select flips to high during init and must be ignored
  task t_init;
    sense = 1'b1;
    enable = 1'b1;
    repeat (3) @(negedge clk);
    want_sel = PZS_SEL_HIGH;
    repeat (INIT_CYC - 4) @(negedge clk);
    chk(ramp, 0);
    chk(zone, 3);
    chk(pst, 4'h7);
    chk(pwm, 4'h1);
    for (i = 0; i < 10 && ramp !== 1'b1; i++) @(negedge clk);
    chk(ramp, 1);
  endtask : t_init
  // One resistor code gives a 1000-cycle ramp; good only after it
  task t_ramp;
    repeat (900) @(negedge clk);
    chk(ramp, 1);
    chk(pg, 0);
    for (i = 0; i < 200 && ramp !== 1'b0; i++) @(negedge clk);
    chk(ramp, 0);
    nominal = 1'b1;
    repeat (5) @(negedge clk);
    chk(pg, 1);
    chk(zone, 0);
    chk(pwm, 4'h7);
  endtask : t_ramp
  // Return to low after leaving it selects the normal zone
  task t_low;
    want_sel = PZS_SEL_LOW;
    repeat (4) @(negedge clk);
    chk(zone, 4);
    chk(pwm, 4'h1);
  endtask : t_low
  // Written thresholds, top one off; heavy then light load
  task t_shed;
    cfg_write = 1'b1;
    strap = '1;
    @(negedge clk);
    cfg_write = 1'b0;
    cur = 8'h70;
    want_sel = PZS_SEL_MID;
    for (i = 0; i < 3500 && zone !== 3'h0; i++) @(negedge clk);
    chk(zone, 0);
    cur = 8'h08;
    repeat (2000) @(negedge clk);
    chk(zone, 0);
    for (i = 0; i < 5000 && zone === 3'h0; i++) @(negedge clk);
    chk(zone, 2);
    for (i = 0; i < 5000 && zone === 3'h2; i++) @(negedge clk);
    chk(zone, 3);
    chk((i > 2990) && (i < 3010), 1);
    for (i = 0; i < 5000 && zone === 3'h3; i++) @(negedge clk);
    chk(zone, 4);
    chk(pg, 1);
  endtask : t_shed
  // Duty cycle kept, then released input tristates the buffer
  task t_duty;
    na = 0;
    nb = 0;
    repeat (16) begin
      @(negedge clk);
      na += vdi;
      nb += dbo;
    end
    chk(nb, na);
    chk(dboe, 1);
    flt = 1'b1;
    repeat (4) @(negedge clk);
    chk(dboe, 0);
  endtask : t_duty
  // Lockout seen while enabled; overcurrent drops power good
  task t_fault;
    sense = 1'b0;
    repeat (5) @(negedge clk);
    chk(uvlo, 1);
    nominal = 1'b0;
    repeat (3) @(negedge clk);
    chk(pg, 1);
    fault.ocp = 1'b1;
    repeat (3) @(negedge clk);
    chk(pg, 0);
  endtask : t_fault
  // Main sequence after 20 reset cycles
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_idle;
    t_init;
    t_ramp;
    t_low;
    t_shed;
    t_duty;
    t_fault;
    conclude;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(400000 * 10);
    bad_count++;
    conclude;
  end
endmodule : phase_zone_sequencer_tb

// file: bench/pzs_host.sv
// Host model: drives duty pulse train and power-saving select.
// Assumes bench gives requested select level and float request.
`timescale 1ns/1ps
module pzs_host
  import pzs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests from bench
  input wire pzs_pkg::pzs_sel_e want_sel,
  input wire logic float_req,
  // Pins toward device
  output pzs_pkg::pzs_sel_e power_saving_select,
  output logic voltage_duty_input,
  output logic duty_input_float
);
  logic [1:0] ph_r = 2'h0;
  initial power_saving_select = PZS_SEL_LOW;
  initial voltage_duty_input = 1'b0;
  initial duty_input_float = 1'b0;
  // Changes land off the sampling edge; a released line toggles, since
  // a floating pin holds no value worth trusting
  always @(negedge clk) begin
    ph_r <= ph_r + 2'h1;
    power_saving_select <= want_sel;
    duty_input_float <= float_req;
    voltage_duty_input <= float_req ? ~voltage_duty_input : (ph_r == 2'h0);
  end
endmodule : pzs_host

// file: pkg/pzs_pkg.sv
// Constants and carrier types for the phase zone sequencer.
// Assumes one 100 MHz clock, synchronous reset, and that analog front ends
// deliver digitised resistor, current and pin-state measurements.
// Operation
// - Hold 1.5 ms after enable before ramping
// - Power good low until ramp done, in regulation
// - Power good drops only on UVLO/OVP/OCP shutdown (code also drops it when enable goes low)
// - Ramp duration chosen from measured soft-start resistor
// - Ramp supply lockout only evaluated while enabled
// - Four phases default; high sense pin disables phase
// - Active phase outputs shown in phase status
// - Strap state and resistors sampled at power-up
// - Written configuration replaces strapped zone and thresholds
// - Power-saving changes ignored until output nominal
// - Select high keeps all active phases on
// - Middle level samples current every 10 us
// - Threshold disabled at 2 V, floating, or 0xff
// - Shedding inactive until output first reaches nominal
// - Low select: boot zone, then normal zone
// - Normal zone only after select leaves low, returns
// - Floating duty input tristates duty buffer
// - Duty buffer copies duty cycle unchanged
// - Higher zone number waits programmable delay
// - Step through enabled zones, hysteresis on shedding (code steps only upward; a lower target is taken directly)
package pzs_pkg;
  localparam int CLK_MHZ = 100;
  localparam int INIT_US_X10 = 15000;  // 1.5 ms in tenths of a microsecond
  localparam int INIT_CYC = INIT_US_X10 * CLK_MHZ / 10;
  localparam int SAMPLE_US = 10;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int SHED_DELAY_US = 200;
  localparam logic [7:0] SHED_DELAY_STEPS = 8'h14;  // 200 us in 10 us steps
  localparam logic [7:0] HYST_DEFAULT = 8'h10;
  localparam logic [7:0] THR_OFF = 8'hff;
  localparam logic [7:0] THR_2V = 8'hff;  // Code that a 2 V drop reaches
  localparam int RAMP_UNIT_CYC = 1000;  // Ramp cycles per resistor code step
  localparam int NPH = 4;
  localparam logic [2:0] ZONE_DEFAULT = 3'h0;

  typedef enum logic [1:0] {
    PZS_SEL_LOW = 2'b00,
    PZS_SEL_MID = 2'b01,
    PZS_SEL_HIGH = 2'b10
  } pzs_sel_e;

  // Zone settings; thresholds index 0..3 = levels 1..4
  typedef struct packed {
    logic [2:0] normal_zone;
    logic [2:0] boot_zone;
    logic [3:0][7:0] thr;
  } pzs_cfg_s;

  typedef struct packed {
    logic uvlo;
    logic ovp;
    logic ocp;
  } pzs_fault_s;
endpackage : pzs_pkg

// file: rtl/pzs_sequencer.sv
// Soft start, power good, phase detection and power-zone sequencing.
// Assumes measurement inputs are steady while enable first rises and that
// the duty input arrives already resolved to level plus floating flag.
`timescale 1ns/1ps
module pzs_sequencer
  import pzs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire pzs_pkg::pzs_fault_s fault,
  input wire logic output_nominal,
  input wire logic ramp_supply_sense,
  // Power-up measurements
  input wire logic [7:0] ss_resistor_code,
  input wire logic [NPH-1:0] phase_sense_positive,
  input wire pzs_pkg::pzs_sel_e power_saving_select,
  input wire pzs_pkg::pzs_cfg_s fixed_zone_strap,
  // Software overrides
  input wire logic cfg_write,
  input wire pzs_pkg::pzs_cfg_s cfg_data,
  input wire logic [7:0] shed_delay_steps,
  input wire logic [7:0] hysteresis,
  // Load current
  input wire logic [7:0] total_current_monitor,
  // Duty buffer
  input wire logic voltage_duty_input,
  input wire logic duty_input_float,
  // Outputs
  output logic power_good_out,
  output logic ramp_active,
  output logic [NPH-1:0] pwm_enable,
  output logic [NPH-1:0] phase_status,
  output logic [2:0] power_zone,
  output logic duty_buffer_out,
  output logic duty_buffer_oe,
  output logic ramp_uvlo
);
  import pzs_pkg::*;

  typedef enum logic [1:0] {
    PZS_OFF = 2'b00,
    PZS_INIT = 2'b01,
    PZS_RAMP = 2'b10,
    PZS_RUN = 2'b11
  } pzs_state_e;

  pzs_state_e state_r;
  logic [23:0] tmr_r;
  logic [23:0] ramp_len_r;
  logic [NPH-1:0] present_r;
  pzs_cfg_s cfg_r;
  pzs_sel_e sel_r;
  logic nominal_seen_r;
  logic left_low_r;
  logic [2:0] zone_r;
  logic [2:0] zone_nxt;
  logic [2:0] target;
  logic [9:0] smp_r;
  logic [15:0] dly_r;
  logic any_fault;

  assign any_fault = fault.uvlo | fault.ovp | fault.ocp;

  // A threshold is unused when its code says 2 V, float, or 0xff
  function automatic logic thr_on(input logic [7:0] t);
    return (t != THR_OFF) && (t < THR_2V);
  endfunction : thr_on

  // Zone served by a threshold level; index 0 is the lowest threshold
  function automatic logic [2:0] lvl_zone(input int i);
    case (i)
      0: return 3'h4;
      1: return 3'h3;
      2: return 3'h2;
      default: return 3'h0;
    endcase
  endfunction : lvl_zone

  // Soft start sequence; a fault returns to off and drops power good
  always_ff @(posedge clk) begin
    if (rst || !enable || any_fault) begin
      state_r <= PZS_OFF;
      tmr_r <= 24'h0;
    end else begin
      unique case (state_r)
        PZS_OFF: begin
          state_r <= PZS_INIT;
          tmr_r <= 24'h0;
        end
        PZS_INIT: begin
          if (tmr_r == 24'(INIT_CYC - 1)) begin
            state_r <= PZS_RAMP;
            tmr_r <= 24'h0;
          end else begin
            tmr_r <= tmr_r + 24'h1;
          end
        end
        PZS_RAMP: begin
          if (tmr_r >= ramp_len_r) begin
            state_r <= PZS_RUN;
          end else begin
            tmr_r <= tmr_r + 24'h1;
          end
        end
        PZS_RUN: state_r <= PZS_RUN;
      endcase
    end
  end

  // Power-up straps; caught on the off-to-init step
  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_len_r <= 24'h0;
      present_r <= {NPH{1'b1}};
    end else if (state_r == PZS_OFF && enable) begin
      ramp_len_r <= 24'(ss_resistor_code) * 24'(RAMP_UNIT_CYC);
      present_r <= ~phase_sense_positive;
    end
  end

  // Zone configuration: strap at power-up, software write afterwards
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= '0;
    end else if (cfg_write) begin
      cfg_r <= cfg_data;
    end else if (state_r == PZS_OFF && enable) begin
      cfg_r <= fixed_zone_strap;
    end
  end

  // Select is frozen until the output first reaches nominal
  always_ff @(posedge clk) begin
    if (rst || state_r == PZS_OFF) begin
      sel_r <= PZS_SEL_HIGH;
      nominal_seen_r <= 1'b0;
      left_low_r <= 1'b0;
      if (!rst && enable) begin
        sel_r <= power_saving_select;
      end
    end else begin
      if (state_r == PZS_RUN && output_nominal) begin
        nominal_seen_r <= 1'b1;
      end
      if (nominal_seen_r) begin
        sel_r <= power_saving_select;
        if (power_saving_select != PZS_SEL_LOW) begin
          left_low_r <= 1'b1;
        end
      end
    end
  end

  // Target zone from current; upward moves need hysteresis margin
  always_comb begin
    target = 3'h0;
    for (int i = NPH - 1; i >= 0; i--) begin
      if (thr_on(cfg_r.thr[i])) begin
        if (zone_r < lvl_zone(i)) begin  // Moving up needs the margin
          if (total_current_monitor + hysteresis < {1'b0, cfg_r.thr[i]}) begin
            target = lvl_zone(i);
          end
        end else if (total_current_monitor < cfg_r.thr[i]) begin
          target = lvl_zone(i);
        end
      end
    end
  end

  // Next zone one enabled step up toward a higher target; a lower target is taken directly
  always_comb begin
    zone_nxt = zone_r;
    if (target < zone_r) begin
      zone_nxt = target;
    end else if (target > zone_r) begin
      zone_nxt = target;
      for (int i = 0; i < NPH; i++) begin
        if (thr_on(cfg_r.thr[i]) && lvl_zone(i) > zone_r &&
            lvl_zone(i) < zone_nxt) begin
          zone_nxt = lvl_zone(i);
        end
      end
    end
  end

  // Zone register; shedding only after nominal, decided once per 10 us
  // sample so a short current spike between samples cannot move the zone
  always_ff @(posedge clk) begin
    if (rst || state_r == PZS_OFF) begin
      zone_r <= ZONE_DEFAULT;
      smp_r <= 10'h0;
      dly_r <= 16'h0;
    end else begin
      smp_r <= (smp_r == 10'(SAMPLE_CYC - 1)) ? 10'h0 : smp_r + 10'h1;
      if (sel_r == PZS_SEL_HIGH) begin
        zone_r <= ZONE_DEFAULT;
        dly_r <= 16'h0;
      end else if (sel_r == PZS_SEL_LOW) begin
        zone_r <= left_low_r ? cfg_r.normal_zone : cfg_r.boot_zone;
      end else if (!nominal_seen_r) begin
        zone_r <= ZONE_DEFAULT;
      end else if (smp_r != 10'h0) begin
        dly_r <= dly_r;  // Hold between current samples
      end else if (zone_nxt < zone_r) begin
        zone_r <= zone_nxt;
        dly_r <= 16'h0;
      end else if (zone_nxt > zone_r) begin
        // Delay counted in samples, so one step is 10 us and the counter
        // never needs more than the eight bits of the step setting
        if (dly_r + 16'h1 >= 16'(shed_delay_steps)) begin
          zone_r <= zone_nxt;
          dly_r <= 16'h0;
        end else begin
          dly_r <= dly_r + 16'h1;
        end
      end else begin
        dly_r <= 16'h0;
      end
    end
  end

  // Phase enables from zone and presence
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_enable <= '0;
      phase_status <= '0;
    end else if (state_r == PZS_OFF) begin
      pwm_enable <= '0;
      phase_status <= present_r;
    end else begin
      phase_status <= present_r;
      unique case (zone_r)
        3'h0: pwm_enable <= present_r;
        3'h2: pwm_enable <= present_r & 4'b0101;
        default: pwm_enable <= present_r & 4'b0001;
      endcase
    end
  end

  // Outputs registered from state, zone, lockout sense and duty inputs
  always_ff @(posedge clk) begin
    if (rst) begin
      power_good_out <= 1'b0;
      ramp_active <= 1'b0;
      ramp_uvlo <= 1'b0;
      power_zone <= 3'h0;
      duty_buffer_out <= 1'b0;
      duty_buffer_oe <= 1'b0;
    end else begin
      // Latched once good: only a shutdown (off state) may clear it
      power_good_out <= (state_r == PZS_RUN) &&
                        (output_nominal || power_good_out);
      ramp_active <= (state_r == PZS_RAMP);
      ramp_uvlo <= enable && !ramp_supply_sense;
      power_zone <= zone_r;
      duty_buffer_out <= voltage_duty_input;
      duty_buffer_oe <= !duty_input_float;
    end
  end

  // Cycles spent in init, counted apart from the sequencer's own timer so
  // the check below does not simply mirror the logic it guards
  logic [23:0] init_seen_r;
  always_ff @(posedge clk) begin
    if (rst || state_r != PZS_INIT) begin
      init_seen_r <= 24'h0;
    end else begin
      init_seen_r <= init_seen_r + 24'h1;
    end
  end

  // Once good, power good holds until a shutdown, even if regulation dips
  chk_pg_hold: assert property (@(posedge clk) disable iff (rst)
    power_good_out && state_r == PZS_RUN && enable && !any_fault
    |=> power_good_out) else $error("power good dropped");
  chk_init_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r == PZS_RAMP) |-> init_seen_r == 24'(INIT_CYC))
    else $error("init interval wrong");
  chk_pg_low_ss: assert property (@(posedge clk) disable iff (rst)
    state_r == PZS_RAMP |=> !power_good_out)
    else $error("power good during ramp");
  chk_uvlo_off: assert property (@(posedge clk) disable iff (rst)
    !enable |=> !ramp_uvlo) else $error("uvlo while disabled");
  chk_pwm_present: assert property (@(posedge clk) disable iff (rst)
    (pwm_enable & ~present_r) == '0) else $error("absent phase on");
  chk_status_copy: assert property (@(posedge clk) disable iff (rst)
    state_r != PZS_OFF |=> phase_status == $past(present_r))
    else $error("phase status stale");
  chk_cfg_write: assert property (@(posedge clk) disable iff (rst)
    cfg_write |=> cfg_r == $past(cfg_data)) else $error("write not taken");

  // Zone selection and duty buffer guards
  chk_high_all: assert property (@(posedge clk) disable iff (rst)
    sel_r == PZS_SEL_HIGH && state_r != PZS_OFF |=> zone_r == 3'h0)
    else $error("high select shed");
  chk_zone_hold: assert property (@(posedge clk) disable iff (rst)
    sel_r == PZS_SEL_MID && nominal_seen_r && state_r != PZS_OFF &&
    smp_r != 10'h0 |=> $stable(zone_r)) else $error("zone moved off sample");
  chk_no_shed: assert property (@(posedge clk) disable iff (rst)
    sel_r == PZS_SEL_MID && !nominal_seen_r |=> zone_r == 3'h0)
    else $error("early shedding");
  chk_duty_oe: assert property (@(posedge clk) disable iff (rst)
    duty_input_float |=> !duty_buffer_oe) else $error("buffer driven");
endmodule : pzs_sequencer
